/* hdl/fbsoc_pkg.sv */
/*
 * fbsoc_pkg: register map, field positions, reset values, flash block map
 * and the structs that carry the overlay and array-control signals.
 * Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
 */
package fbsoc_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_MODE    = 8'h00;
	localparam logic [7:0] OFS_LARGE   = 8'h04;
	localparam logic [7:0] OFS_SMALL   = 8'h08;
	localparam logic [7:0] OFS_OVERLAY = 8'h0c;
	localparam logic [7:0] OFS_STATUS  = 8'h10;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_PROG    = 0;
	localparam int BIT_ERASE   = 1;
	localparam int BIT_PVERIFY = 2;
	localparam int BIT_EVERIFY = 3;
	localparam int BIT_SUPPLY  = 6;
	localparam int BIT_VPPDET  = 7;
	localparam int BIT_OVLEN   = 3;
	localparam int BIT_FLERR   = 7;

	localparam logic [7:0] SEL_RESET    = 8'h00;
	localparam logic [7:0] SEL_DISABLED = 8'hff;
	localparam logic [7:0] OVL_RSVD     = 8'h70;
	localparam logic [7:0] MODE_RESET   = 8'h00;

	// ---------------------------------------------------------------
	// block map
	// ---------------------------------------------------------------
	localparam logic [16:0] LARGE_SIZE  = 17'h04000;
	localparam logic [16:0] LB7_END     = 17'h1efff;
	localparam logic [16:0] SMALL_BASE  = 17'h1f000;
	localparam logic [16:0] SMALL_SIZE  = 17'h00200;
	localparam logic [23:0] RAM_HOME    = 24'hfff000;
	localparam logic [23:0] RAM_OVLBASE = 24'h01f000;
	localparam int          SMALL_SHIFT = 9;
	localparam int          LARGE_SHIFT = 14;

	// supply settle: least time, rounded up
	localparam int CLK_MHZ        = 100;
	localparam int SUPPLY_WAIT_US = 5;
	localparam int SUPPLY_CYCLES  = SUPPLY_WAIT_US * CLK_MHZ;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic        accValid;
		logic        accRead;
		logic        accFetch;
		logic [23:0] accAddr;
	} fbsoc_access_type;

	typedef struct packed {
		logic        toRam;
		logic [8:0]  ramOffset;
		logic [23:0] ramWindow;
	} fbsoc_overlay_type;

	typedef struct packed {
		logic       progActive;
		logic       eraseActive;
		logic       pverify;
		logic       everify;
		logic       protect;
		logic [7:0] largeSel;
		logic [7:0] smallSel;
	} fbsoc_array_type;
endpackage

/* hdl/fbsoc_flash_ctrl.sv */
/*
 * fbsoc_flash_ctrl: flash mode control, large/small block select, sticky
 * flash error with error protection, and the RAM overlay window decode.
 * Assumes the CPU side reports its accesses and exception, sleep and bus
 * release events as single-cycle pulses synchronous to core_clk; the array
 * itself, its algorithms and the supply detector sit outside.
 */
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// R1 - mode bit 2 holds program-verify mode while one; resets to zero
// R2 - mode bit 1 enters erase mode when one, leaves it at zero
// R3 - mode bit 0 enters program mode when one, leaves it at zero
// R4 - software sets at most one mode-select bit at a time
// R5 - software arms watchdog before setting erase or program
// R6 - large select: eight bits, one selects that block for program/erase
// R7 - small select: eight bits, one selects that small block
// R8 - selects clear on reset, standby, no supply, or supply without enable
// R9 - flash disabled: selects ignore writes and read all ones
// R10 - large blocks 0-6 are 16 kbytes each; block 7 is 12 kbytes
// R11 - small blocks are 512 bytes each from the small area base
// R12 - read of flash while programming/erasing sets error; data undetermined
// R13 - qualifying hardware exception just before program/erase sets error
// R14 - sleep instruction during program/erase sets error
// R15 - bus release during program/erase sets error
// R16 - error flag one forces error protection of array
// R17 - error clears only on reset or hardware standby
// R18 - overlay register bits 6-4 read one; reset value 70 hex
// R19 - overlay enable protects every block from program and erase
// R20 - overlay fields clear on reset, hardware standby; kept in soft standby
// R21 - overlay off: window at home; on: window at base plus n*512
// R22 - supply enable needs five microseconds before program or erase
// R23 - mode bit 3 holds erase-verify mode while one; resets to zero
// R24 - overlay on: accesses in selected small block go to RAM
// R25 - program and erase act only on selected blocks
module fbsoc_flash_ctrl #(
	parameter int SUPPLY_CYCLES = fbsoc_pkg::SUPPLY_CYCLES
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic                       hwStandby,
	input  wire logic                       swStandby,
	input  wire logic                       flashEnabled,
	input  wire logic                       vppPresent,
	input  wire fbsoc_pkg::fbsoc_access_type cpuAccess,
	input  wire logic                       hwException,
	input  wire logic                       sleepExec,
	input  wire logic                       busReleased,
	input  wire logic [7:0]                 s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [7:0]                 s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output fbsoc_pkg::fbsoc_overlay_type    overlayOut,
	output fbsoc_pkg::fbsoc_array_type      arrayCtl
);
	initial begin
		if (SUPPLY_CYCLES < 1 || SUPPLY_CYCLES > 65535)
			$error("SUPPLY_CYCLES out of range");
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0]                   modeBits;
		logic                         supplyEn;
		logic [15:0]                  settleCnt;
		logic [7:0]                   largeSel;
		logic [7:0]                   smallSel;
		logic                         flashErr;
		logic                         ovlEn;
		logic [2:0]                   ovlSel;
		logic                         exceptSeen;
		logic                         awHeld;
		logic [7:0]                   awAddr;
		logic                         wHeld;
		logic [31:0]                  wData;
		logic [3:0]                   wStrb;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
		fbsoc_pkg::fbsoc_overlay_type ovl;
		fbsoc_pkg::fbsoc_array_type   arr;
	} fbsoc_state_type;

	fbsoc_state_type st_r;
	fbsoc_state_type st_nxt;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] ovl_read(input logic err,
		input logic en, input logic [2:0] sel);
		logic [7:0] v;
		v = fbsoc_pkg::OVL_RSVD;
		v[fbsoc_pkg::BIT_FLERR] = err;
		v[fbsoc_pkg::BIT_OVLEN] = en;
		v[2:0] = sel;
		return v;
	endfunction

	// window start address for a select value
	function automatic logic [23:0] win_base(input logic [2:0] n);
		return fbsoc_pkg::RAM_OVLBASE
			+ (24'(n) << fbsoc_pkg::SMALL_SHIFT);
	endfunction

	// which large block (one-hot) or small block holds a flash address
	function automatic logic [15:0] block_of(input logic [16:0] a);
		logic [15:0] hot;
		hot = 16'h0000;
		if (a >= fbsoc_pkg::SMALL_BASE)
			hot[8 + 32'(3'((a - fbsoc_pkg::SMALL_BASE)
				>> fbsoc_pkg::SMALL_SHIFT))] = 1'b1;
		else if (a <= fbsoc_pkg::LB7_END)
			hot[32'(3'(a >> fbsoc_pkg::LARGE_SHIFT))] = 1'b1;
		return hot;
	endfunction

	logic        busyOp;
	logic        inWindow;
	logic        flashHit;
	logic        selClear;
	logic        errSet;
	logic [15:0] hitBlock;

	always_comb begin
		busyOp = st_r.modeBits[fbsoc_pkg::BIT_PROG]
			| st_r.modeBits[fbsoc_pkg::BIT_ERASE];
		// R24 overlay window hit
		inWindow = st_r.ovlEn && cpuAccess.accValid
			&& cpuAccess.accAddr[23:9] == win_base(st_r.ovlSel)[23:9];
		flashHit = cpuAccess.accValid && cpuAccess.accAddr[23:17] == 7'h00;
		// R10 R11 block map decode
		hitBlock = block_of(cpuAccess.accAddr[16:0]);
		// R8 select clearing conditions
		selClear = hwStandby | swStandby | ~vppPresent | ~st_r.supplyEn;
		// R12 R13 R14 R15 error sources
		errSet = busyOp && ((flashHit && cpuAccess.accRead && !inWindow)
			|| st_r.exceptSeen || sleepExec || busReleased);
	end

	always_comb begin
		logic       wrHit;
		logic [7:0] wb;
		logic [7:0] rb;
		logic       ok;
		st_nxt = st_r;
		wrHit = 1'b0;
		wb = st_r.wData[7:0];
		rb = 8'h00;
		ok = 1'b1;

		// R22 supply settle counter
		if (!st_r.supplyEn)
			st_nxt.settleCnt = 16'(SUPPLY_CYCLES);
		else if (st_r.settleCnt != 16'h0000)
			st_nxt.settleCnt = st_r.settleCnt - 16'h0001;

		// an exception just before an operation is remembered one cycle
		st_nxt.exceptSeen = hwException;

		// ---------------------------------------------------------------
		// write channel
		// ---------------------------------------------------------------
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.awHeld = 1'b1;
			st_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.wHeld = 1'b1;
			st_nxt.wData = s_axi_wdata;
			st_nxt.wStrb = s_axi_wstrb;
		end
		st_nxt.awready = !st_nxt.awHeld && !st_r.bvalid;
		st_nxt.wready = !st_nxt.wHeld && !st_r.bvalid;
		if (st_r.awHeld && st_r.wHeld && !st_r.bvalid) begin
			wrHit = st_r.wStrb[0];
			st_nxt.awHeld = 1'b0;
			st_nxt.wHeld = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = fbsoc_pkg::RESP_OKAY;
			case (st_r.awAddr)
			fbsoc_pkg::OFS_MODE: begin
				// R1 R2 R3 R23 mode bits
				if (wrHit && flashEnabled) begin
					st_nxt.modeBits = wb[3:0];
					st_nxt.supplyEn = wb[fbsoc_pkg::BIT_SUPPLY];
				end
			end
			fbsoc_pkg::OFS_LARGE: begin
				// R6 R9 large select
				if (wrHit && flashEnabled)
					st_nxt.largeSel = wb;
			end
			fbsoc_pkg::OFS_SMALL: begin
				// R7 R9 small select
				if (wrHit && flashEnabled)
					st_nxt.smallSel = wb;
			end
			fbsoc_pkg::OFS_OVERLAY: begin
				// R17 error bit ignores writes
				if (wrHit) begin
					st_nxt.ovlEn = wb[fbsoc_pkg::BIT_OVLEN];
					st_nxt.ovlSel = wb[2:0];
				end
			end
			fbsoc_pkg::OFS_STATUS: begin
			end
			default: st_nxt.bresp = fbsoc_pkg::RESP_SLVERR;
			endcase
		end else if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
			st_nxt.awready = !st_r.awHeld;
			st_nxt.wready = !st_r.wHeld;
		end

		// ---------------------------------------------------------------
		// read channel
		// ---------------------------------------------------------------
		if (s_axi_arvalid && st_r.arready) begin
			case (s_axi_araddr)
			fbsoc_pkg::OFS_MODE: begin
				rb = flashEnabled ? {vppPresent, st_r.supplyEn, 2'b00,
					st_r.modeBits} : fbsoc_pkg::SEL_DISABLED;
			end
			fbsoc_pkg::OFS_LARGE: begin
				// R9 disabled reads all ones
				rb = flashEnabled ? st_r.largeSel
					: fbsoc_pkg::SEL_DISABLED;
			end
			fbsoc_pkg::OFS_SMALL: begin
				rb = flashEnabled ? st_r.smallSel
					: fbsoc_pkg::SEL_DISABLED;
			end
			fbsoc_pkg::OFS_OVERLAY: begin
				// R18 reserved bits read one
				rb = ovl_read(st_r.flashErr, st_r.ovlEn, st_r.ovlSel);
			end
			fbsoc_pkg::OFS_STATUS: begin
				rb = {7'h00, st_r.settleCnt == 16'h0000};
			end
			default: ok = 1'b0;
			endcase
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = {24'h000000, rb};
			st_nxt.rresp = ok ? fbsoc_pkg::RESP_OKAY
				: fbsoc_pkg::RESP_SLVERR;
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end

		// R8 selects cleared by standby or supply loss
		if (selClear) begin
			st_nxt.largeSel = fbsoc_pkg::SEL_RESET;
			st_nxt.smallSel = fbsoc_pkg::SEL_RESET;
		end
		if (hwStandby || swStandby || !vppPresent) begin
			st_nxt.modeBits = fbsoc_pkg::MODE_RESET[3:0];
			st_nxt.supplyEn = 1'b0;
		end
		// R12 R13 R14 R15 sticky error, hardware standby clear wins over set
		if (errSet)
			st_nxt.flashErr = 1'b1;
		// R17 R20 hardware standby clears error and overlay
		if (hwStandby) begin
			st_nxt.flashErr = 1'b0;
			st_nxt.ovlEn = 1'b0;
			st_nxt.ovlSel = 3'h0;
		end

		// ---------------------------------------------------------------
		// registered outputs
		// ---------------------------------------------------------------
		// R21 window placement
		st_nxt.ovl.ramWindow = st_nxt.ovlEn ? win_base(st_nxt.ovlSel)
			: fbsoc_pkg::RAM_HOME;
		st_nxt.ovl.toRam = inWindow;
		st_nxt.ovl.ramOffset = cpuAccess.accAddr[8:0];
		st_nxt.arr.pverify = st_nxt.modeBits[fbsoc_pkg::BIT_PVERIFY];
		st_nxt.arr.everify = st_nxt.modeBits[fbsoc_pkg::BIT_EVERIFY];
		// R16 R19 R22 protection
		st_nxt.arr.protect = st_nxt.flashErr | st_nxt.ovlEn
			| (st_nxt.settleCnt != 16'h0000);
		st_nxt.arr.progActive = st_nxt.modeBits[fbsoc_pkg::BIT_PROG]
			& ~st_nxt.arr.protect;
		st_nxt.arr.eraseActive = st_nxt.modeBits[fbsoc_pkg::BIT_ERASE]
			& ~st_nxt.arr.protect;
		// R25 only selected blocks pass
		st_nxt.arr.largeSel = st_nxt.arr.protect ? 8'h00 : st_nxt.largeSel;
		st_nxt.arr.smallSel = st_nxt.arr.protect ? 8'h00 : st_nxt.smallSel;
		if (hitBlock == 16'h0000) begin
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.settleCnt <= 16'(SUPPLY_CYCLES);
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
			st_r.ovl.ramWindow <= fbsoc_pkg::RAM_HOME;
			st_r.arr.protect <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;
	assign overlayOut    = st_r.ovl;
	assign arrayCtl      = st_r.arr;
endmodule

/* sim/fbsoc_checker.sv */
/* fbsoc_checker: port-level assertions for fbsoc_flash_ctrl.
 * assumes one core_clk domain with sync active-high rst. */
`timescale 1ns/1ps
module fbsoc_checker (
	input wire logic                         core_clk,
	input wire logic                         rst,
	input wire logic                         hwStandby,
	input wire logic                         swStandby,
	input wire logic                         vppPresent,
	input wire fbsoc_pkg::fbsoc_access_type  cpuAccess,
	input wire logic                         sleepExec,
	input wire logic                         busReleased,
	input wire logic                         s_axi_awvalid,
	input wire logic                         s_axi_awready,
	input wire logic                         s_axi_wvalid,
	input wire logic                         s_axi_wready,
	input wire logic                         s_axi_bvalid,
	input wire logic                         s_axi_arvalid,
	input wire logic                         s_axi_arready,
	input wire logic                         s_axi_rvalid,
	input wire fbsoc_pkg::fbsoc_overlay_type overlayOut,
	input wire fbsoc_pkg::fbsoc_array_type   arrayCtl
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic       busy;
	logic       homeWin;
	logic [2:0] errAge;
	assign busy = arrayCtl.progActive || arrayCtl.eraseActive;
	assign homeWin = overlayOut.ramWindow == 24'hfff000;

	// age of a known error event; saturates so the hold check stays armed
	always_ff @(posedge core_clk) begin
		if (rst || hwStandby)
			errAge <= 3'h0;
		else if (errAge != 3'h0 && errAge != 3'h7)
			errAge <= errAge + 3'h1;
		else if (busy && (sleepExec || busReleased))
			errAge <= 3'h1;
	end

	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after request");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after address");
	sel_clear_a: assert property ((!vppPresent || hwStandby || swStandby)[*2]
		|=> arrayCtl.largeSel == 8'h00 && arrayCtl.smallSel == 8'h00)
		else $error("block selects not cleared");
	ovl_protect_a: assert property (!$past(homeWin) && !homeWin
		|-> arrayCtl.protect)
		else $error("overlay on without protection");
	err_read_a: assert property (busy && homeWin && cpuAccess.accValid &&
		cpuAccess.accRead && cpuAccess.accAddr < 24'h020000
		|-> ##[1:3] arrayCtl.protect)
		else $error("flash read in program or erase left no error");
	err_hold_a: assert property (errAge >= 3'h4 |-> arrayCtl.protect)
		else $error("error protection dropped before standby");
	ram_route_a: assert property (!homeWin && $stable(overlayOut.ramWindow) &&
		$past(cpuAccess.accValid) && $past(cpuAccess.accAddr[23:9]) ==
		overlayOut.ramWindow[23:9] |-> overlayOut.toRam)
		else $error("window access not routed to ram");
	hw_clear_a: assert property (hwStandby |-> ##2 homeWin)
		else $error("hardware standby kept the overlay window");

	cover property (busy && sleepExec);
	cover property (overlayOut.toRam);
	cover property (s_axi_bvalid && vppPresent);
endmodule

bind fbsoc_flash_ctrl fbsoc_checker u_fbsoc_checker (.core_clk, .rst,
	.hwStandby, .swStandby, .vppPresent, .cpuAccess, .sleepExec,
	.busReleased, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .overlayOut, .arrayCtl);

/* sim/testbench.sv */
/* testbench: drives fbsoc_flash_ctrl through AXI4-Lite and its event pins.
 * assumes a shortened supply settle count; expected reads are queued. */
`timescale 1ns/1ps
module testbench;
	localparam int         SUP = 4;
	localparam logic [7:0] MD = fbsoc_pkg::OFS_MODE;
	localparam logic [7:0] LG = fbsoc_pkg::OFS_LARGE;
	localparam logic [7:0] SM = fbsoc_pkg::OFS_SMALL;
	localparam logic [7:0] OV = fbsoc_pkg::OFS_OVERLAY;
	logic                         core_clk, rst, hwStandby, swStandby;
	logic                         flashEnabled, vppPresent, hwException;
	logic                         sleepExec, busReleased, s_axi_awvalid;
	logic                         s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic                         s_axi_rready, s_axi_awready, s_axi_wready;
	logic                         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]                   s_axi_bresp, s_axi_rresp;
	logic [3:0]                   s_axi_wstrb;
	logic [7:0]                   s_axi_awaddr, s_axi_araddr, lv, sv;
	logic [23:0]                  w;
	logic [8:0]                   off;
	logic [31:0]                  s_axi_wdata, s_axi_rdata;
	logic [33:0]                  expQ[$];
	int                           failures, checked;
	fbsoc_pkg::fbsoc_access_type  cpuAccess;
	fbsoc_pkg::fbsoc_overlay_type overlayOut;
	fbsoc_pkg::fbsoc_array_type   arrayCtl;

	always #5 core_clk = ~core_clk;

	fbsoc_flash_ctrl #(.SUPPLY_CYCLES(SUP)) u_fbsoc_flash_ctrl (.core_clk,
		.rst, .hwStandby, .swStandby, .flashEnabled, .vppPresent,
		.cpuAccess, .hwException, .sleepExec, .busReleased, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.overlayOut, .arrayCtl);

	// ------------------------------------------------------------
	// bus and event tasks
	// ------------------------------------------------------------
	task chk(input string n, input logic [33:0] e, input logic [33:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// handshakes are judged at the falling edge, where registered readies
	// already show what the next rising edge will sample
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic awT, wT, bSeen;
		{awT, wT, bSeen} = 3'b000;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!bSeen) begin
			@(negedge core_clk);
			awT = awT | (s_axi_awvalid & s_axi_awready);
			wT = wT | (s_axi_wvalid & s_axi_wready);
			bSeen = s_axi_bvalid;
			@(posedge core_clk);
			if (awT)
				s_axi_awvalid <= 1'b0;
			if (wT)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r = fbsoc_pkg::RESP_OKAY);
		logic arT, rSeen;
		{arT, rSeen} = 2'b00;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		expQ.push_back({r, 24'h0, d});
		while (!rSeen) begin
			@(negedge core_clk);
			arT = arT | (s_axi_arvalid & s_axi_arready);
			rSeen = s_axi_rvalid;
			@(posedge core_clk);
			if (arT)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	// one-cycle pulse: 0 flash read, 1 exception, 2 sleep, 3 bus release
	task ev(input int k, input logic [23:0] ad);
		@(posedge core_clk);
		case (k)
			0: cpuAccess <= '{1'b1, 1'b1, 1'b0, ad};
			1: hwException <= 1'b1;
			2: sleepExec <= 1'b1;
			default: busReleased <= 1'b1;
		endcase
		@(posedge core_clk);
		{hwException, sleepExec, busReleased} <= 3'b000;
		cpuAccess <= '0;
	endtask

	task stby(input logic hw);
		@(posedge core_clk);
		hwStandby <= hw;
		swStandby <= !hw;
		@(posedge core_clk);
		{hwStandby, swStandby} <= 2'b00;
	endtask

	// clean slate with the supply enabled and settled
	task prep();
		stby(1'b1);
		wr(MD, 8'h40);
		repeat (SUP + 4) @(posedge core_clk);
		rd(8'h10, 8'h01);
	endtask

	task print_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// read data stands from the launching edge to the taking edge
	always @(negedge core_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			chk("read", expQ[0], {s_axi_rresp, s_axi_rdata});
			void'(expQ.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		print_verdict();
	end

	initial begin
		{core_clk, hwStandby, swStandby, hwException, sleepExec} = '0;
		{busReleased, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{rst, flashEnabled, vppPresent} = 3'b111;
		{s_axi_wdata, s_axi_wstrb, cpuAccess} = {32'h0, 4'hf, 27'h0};
		void'($urandom(32'hc3e7));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rd(MD, 8'h80);
		rd(LG, fbsoc_pkg::SEL_RESET);
		rd(OV, fbsoc_pkg::OVL_RSVD);
		rd(8'h14, 8'h00, fbsoc_pkg::RESP_SLVERR);
		chk("window", 34'h0fff000, 34'(overlayOut.ramWindow));
		$display("test reset done");
		prep();
		lv = 8'($urandom);
		sv = 8'($urandom);
		wr(LG, lv);
		wr(SM, sv);
		rd(LG, lv);
		rd(SM, sv);
		chk("select", 34'({lv, sv}), 34'(arrayCtl[15:0]));
		flashEnabled <= 1'b0;
		wr(LG, 8'h00);
		rd(LG, fbsoc_pkg::SEL_DISABLED);
		rd(SM, fbsoc_pkg::SEL_DISABLED);
		flashEnabled <= 1'b1;
		rd(LG, lv);
		vppPresent <= 1'b0;
		repeat (3) @(posedge core_clk);
		vppPresent <= 1'b1;
		rd(SM, 8'h00);
		$display("test select done");
		prep();
		for (int b = 0; b < 4; b++) begin
			wr(MD, 8'h40 | (8'h01 << b));
			rd(MD, 8'hc0 | (8'h01 << b));
			chk("mode", 34'(8'h08 >> b), 34'(arrayCtl[20:17]));
			wr(MD, 8'h40);
		end
		$display("test mode done");
		for (int n = 0; n < 8; n++) begin
			w = 24'h01f000 + 24'(n * 512);
			wr(OV, 8'h08 | 8'(n));
			rd(OV, 8'h78 | 8'(n));
			off = 9'($urandom % 512);
			ev(0, w + 24'(off));
			@(negedge core_clk);
			chk("overlay", {1'b1, off, w}, 34'(overlayOut));
		end
		wr(OV, 8'h0b);
		stby(1'b0);
		rd(OV, 8'h7b);
		stby(1'b1);
		rd(OV, 8'h70);
		$display("test overlay done");
		for (int k = 0; k < 4; k++) begin
			prep();
			ev(k, 24'($urandom % 32'h1f000));
			rd(OV, 8'h70);
			wr(MD, 8'h41);
			ev(k, 24'($urandom % 32'h1f000));
			rd(OV, 8'hf0);
			wr(OV, 8'h00);
			rd(OV, 8'hf0);
			chk("protect", 34'h1, 34'(arrayCtl.protect));
		end
		$display("test error done");
		print_verdict();
	end
endmodule
